// [hdl/ugpr_pkg.sv]
// ugpr_pkg: constants shared by the user glyph pattern store design
// assumes: single 250 MHz clock domain, 8-bit host data path
package ugpr_pkg;
  // ==========================================================
  // store geometry
  localparam int STORE_DEPTH = 32;
  localparam int ADDR_W      = 5;
  localparam int DATA_W      = 8;
  localparam int DOT_W       = 5;
  localparam int ROW8_W      = 3;
  localparam int ROW12_W     = 4;
  localparam logic [3:0] ROW12_LAST = 4'hB;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [4:0] RESET_ADDR = 5'h00;
  localparam logic [4:0] DOTS_DARK  = 5'h00;
  localparam logic [4:0] ADDR_STEP  = 5'h01;

  // ==========================================================
  // apb register map (byte addresses)
  localparam logic [7:0] REG_CTRL    = 8'h00; // bit0 enable, bit1 font12, bit2 down
  localparam logic [7:0] REG_ADDR    = 8'h04; // pattern address counter
  localparam logic [7:0] REG_DATA    = 8'h08; // pattern data port, steps address
  localparam logic [7:0] REG_STATUS  = 8'h0C; // bit0 set after a data read
  localparam int CTRL_EN    = 0;
  localparam int CTRL_FONT  = 1;
  localparam int CTRL_DOWN  = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // ==========================================================
  // access engine states
  typedef enum logic [2:0] {
    UGPR_IDLE = 3'b001,
    UGPR_READ = 3'b010,
    UGPR_DONE = 3'b100
  } ugpr_state_t;
endpackage

// [hdl/ugpr_store.sv]
// ugpr_store: 32 x 8 pattern memory, two registered read ports
// assumes: one clock, host port writes, display port only reads
`timescale 1ns/1ns
`default_nettype none
module ugpr_store
  import ugpr_pkg::*;
(
  input  wire logic              clk,    // system clock
  input  wire logic              we,     // host write strobe
  input  wire logic [ADDR_W-1:0] waddr,  // host address
  input  wire logic [DATA_W-1:0] wdata,  // host write byte
  output var  logic [DATA_W-1:0] hdata,  // host read byte
  input  wire logic [ADDR_W-1:0] raddr,  // display row address
  output var  logic [DATA_W-1:0] rdata   // display row byte
);
  logic [DATA_W-1:0] mem [STORE_DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    hdata <= mem[waddr];
  end

  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// [hdl/ugpr_glyph_map.sv]
// ugpr_glyph_map: character code and row to pattern address
// assumes: purely combinational, used by the display fetch path
`timescale 1ns/1ns
`default_nettype none
module ugpr_glyph_map
  import ugpr_pkg::*;
(
  input  wire logic              font12, // 1 = 5x12 font
  input  wire logic              enable, // user store enabled
  input  wire logic [7:0]        code,   // character code
  input  wire logic [3:0]        row,    // glyph row
  output logic                   use_ram,// glyph from user store
  output logic [ADDR_W-1:0]      addr,   // pattern address
  output logic                   shown   // row is a displayed one
);
  always_comb begin
    use_ram = enable && (code[7:4] == 4'h0);
    if (font12) begin
      addr  = {code[1], row};
      shown = (row <= ROW12_LAST);
    end else begin
      addr  = {code[1:0], row[2:0]};
      shown = 1'b1;
    end
  end
endmodule
`default_nettype wire

// [hdl/ugpr_top.sv]
// ugpr_top: user glyph pattern store with apb access and display fetch
// assumes: apb master in the clk domain; display scanner gives code+row
`timescale 1ns/1ns
`default_nettype none
//
// Operation
// - the store holds 32 bytes, four 5x8 glyphs or two 5x12 glyphs.
// - user glyphs show only after the host enables the store.
// - when enabled, codes with upper nibble zero use the user store.
// - in 5x8 mode address bits 2..0 pick the row, bits 4..3 are code 1..0.
// - each write stores one row, host data bit n to pattern bit n.
// - a one bit lights its dot, a zero bit leaves it dark.
// - each store write steps the address by one in the set direction.
// - in 5x8 mode only bits 4..0 are shown, bits 7..5 stay storage.
// - 5x8 glyph choice ignores code bits 3 and 2.
// - in 5x12 mode address bits 3..0 pick the row, bit 4 is code bit 1.
// - in 5x12 mode rows 0..B show bits 4..0; rows C..F and bits 7..5 not.
// - 5x12 glyph choice ignores code bits 3, 2 and 0.
// - a data read returns the stored byte and steps the address.
module ugpr_top
  import ugpr_pkg::*;
(
  input  wire logic              clk,       // 250 MHz clock
  input  wire logic              rstn,      // async reset, active low
  input  wire logic              psel,      // apb select
  input  wire logic              penable,   // apb enable
  input  wire logic              pwrite,    // apb direction
  input  wire logic [7:0]        paddr,     // apb byte address
  input  wire logic [31:0]       pwdata,    // apb write data
  output logic      [31:0]       prdata,    // apb read data
  output logic                   pready,    // apb ready
  output logic                   pslverr,   // apb error
  input  wire logic [7:0]        disp_code, // character code to render
  input  wire logic [3:0]        disp_row,  // glyph row to render
  input  wire logic [4:0]        rom_dots,  // fixed glyph rom row dots
  output logic      [4:0]        dots,      // row dots to the display
  output logic                   dots_ram   // dots came from the store
);
  // ==========================================================
  // control registers
  logic [2:0]        ctrl;
  logic [ADDR_W-1:0] addr_cnt;
  logic              read_flag;
  ugpr_state_t       state;

  logic setup;
  logic wr_ctrl;
  logic wr_addr;
  logic wr_data;
  logic rd_data;
  logic mapped;
  logic step;
  logic [ADDR_W-1:0] next_addr;

  assign setup   = psel && !penable && state == UGPR_IDLE;
  assign mapped  = paddr == REG_CTRL || paddr == REG_ADDR ||
                   paddr == REG_DATA || paddr == REG_STATUS;
  assign wr_ctrl = setup && pwrite && paddr == REG_CTRL;
  assign wr_addr = setup && pwrite && paddr == REG_ADDR;
  assign wr_data = setup && pwrite && paddr == REG_DATA;
  assign rd_data = setup && !pwrite && paddr == REG_DATA;
  assign step    = wr_data || rd_data;

  always_comb begin
    if (ctrl[CTRL_DOWN]) begin
      next_addr = addr_cnt - ADDR_STEP;
    end else begin
      next_addr = addr_cnt + ADDR_STEP;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= pwdata[2:0];
    end
  end

  // ==========================================================
  // address counter: loaded by software, stepped by data access
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addr_cnt <= RESET_ADDR;
    end else if (wr_addr) begin
      addr_cnt <= pwdata[ADDR_W-1:0];
    end else if (step) begin
      addr_cnt <= next_addr;
    end
  end

  // set on a data read; the host must reload a display address after
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      read_flag <= 1'b0;
    end else if (rd_data) begin
      read_flag <= 1'b1;
    end else if (setup && pwrite && paddr == REG_STATUS) begin
      read_flag <= 1'b0;
    end
  end

  // ==========================================================
  // pattern store
  logic [DATA_W-1:0] host_byte;
  logic [DATA_W-1:0] row_byte;
  logic [ADDR_W-1:0] map_addr;
  logic              map_ram;
  logic              map_shown;

  ugpr_store u_store (
    .clk   (clk),
    .we    (wr_data),
    .waddr (addr_cnt),
    .wdata (pwdata[DATA_W-1:0]),
    .hdata (host_byte),
    .raddr (map_addr),
    .rdata (row_byte)
  );

  ugpr_glyph_map u_map (
    .font12  (ctrl[CTRL_FONT]),
    .enable  (ctrl[CTRL_EN]),
    .code    (disp_code),
    .row     (disp_row),
    .use_ram (map_ram),
    .addr    (map_addr),
    .shown   (map_shown)
  );

  // ==========================================================
  // apb engine: writes and register reads answer in the access cycle, data reads one later
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= UGPR_IDLE;
    end else begin
      case (state)
        UGPR_IDLE: begin
          if (setup) begin
            state <= (rd_data) ? UGPR_READ : UGPR_DONE;
          end
        end
        UGPR_READ: state <= UGPR_DONE;
        UGPR_DONE: state <= UGPR_IDLE;
        default:   state <= UGPR_IDLE;
      endcase
    end
  end

  logic [31:0] rd_mux;
  always_comb begin
    case (paddr)
      REG_CTRL:   rd_mux = {29'h0, ctrl};
      REG_ADDR:   rd_mux = {27'h0, addr_cnt};
      REG_DATA:   rd_mux = {24'h0, host_byte};
      REG_STATUS: rd_mux = {31'h0, read_flag};
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= (state == UGPR_IDLE && setup && !rd_data) ||
                 state == UGPR_READ;
      pslverr <= (state == UGPR_IDLE && setup && !mapped);
      if (state == UGPR_READ || (setup && !rd_data && !pwrite)) begin
        prdata <= rd_mux;
      end
    end
  end

  // ==========================================================
  // display fetch: dots two cycles behind code and row
  logic ram_q;
  logic shown_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ram_q   <= 1'b0;
      shown_q <= 1'b0;
    end else begin
      ram_q   <= map_ram;
      shown_q <= map_shown;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dots     <= DOTS_DARK;
      dots_ram <= 1'b0;
    end else if (ram_q) begin
      dots_ram <= 1'b1;
      if (shown_q) begin
        dots <= row_byte[DOT_W-1:0];
      end else begin
        dots <= DOTS_DARK;
      end
    end else begin
      dots_ram <= 1'b0;
      dots     <= rom_dots;
    end
  end
endmodule
`default_nettype wire

// [test/ugpr_top_monitor.sv]
// ugpr_top_monitor: port assertions for ugpr_top
// assumes: bound to ugpr_top, the apb master leaves a gap after each access
`timescale 1ns/1ns
`default_nettype none
module ugpr_top_monitor
  import ugpr_pkg::*;
(
  input wire logic        clk,       // clock
  input wire logic        rstn,      // reset, active low
  input wire logic        psel,      // apb select
  input wire logic        penable,   // apb enable
  input wire logic        pwrite,    // apb direction
  input wire logic [7:0]  paddr,     // apb address
  input wire logic [31:0] pwdata,    // apb write data
  input wire logic        pready,    // apb ready
  input wire logic        pslverr,   // apb error
  input wire logic [7:0]  disp_code, // character code
  input wire logic [3:0]  disp_row,  // glyph row
  input wire logic [4:0]  rom_dots,  // fixed rom dots
  input wire logic [4:0]  dots,      // dots out
  input wire logic        dots_ram   // dots from store
);
  // ==========================================================
  // shadow of enable and font, taken at completed ctrl writes
  logic [1:0] ctrl;
  wire        up0 = disp_code[7:4] == 4'h0;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      ctrl <= 2'h0;
    else if (pready && pwrite && !pslverr && paddr == REG_CTRL)
      ctrl <= pwdata[1:0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ==========================================================
  // assertions
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready high two cycles");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access");
  a_write_fast: assert property (psel && !penable && pwrite |=> pready)
    else $error("write not answered at once");
  a_read_wait: assert property (
    psel && !penable && !pwrite && paddr == REG_DATA |=> !pready ##1 pready)
    else $error("data read latency wrong");
  // rom dots are taken one cycle after code and row
  a_rom_pass: assert property (
    !up0 |-> ##2 !dots_ram && dots == $past(rom_dots, 1))
    else $error("rom dots not passed");
  // the shadow trails the design's control by one cycle
  a_ram_sel: assert property (
    up0 ##1 ctrl[0] |=> dots_ram)
    else $error("store not selected");
  a_dark_rows: assert property (
    up0 && disp_row > ROW12_LAST ##1 ctrl == 2'h3 |=> dots == DOTS_DARK)
    else $error("hidden 5x12 row shown");
endmodule
bind ugpr_top ugpr_top_monitor i_ugpr_top_monitor (.clk, .rstn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .disp_code,
  .disp_row, .rom_dots, .dots, .dots_ram);
`default_nettype wire

// [test/ugpr_host.sv]
// ugpr_host: apb master standing in for the host cpu
// assumes: xfer is called just after a rising edge of clk
`timescale 1ns/1ns
`default_nettype none
module ugpr_host (
  input  wire logic        clk,     // clock
  output logic             psel,    // apb select
  output logic             penable, // apb enable
  output logic             pwrite,  // apb direction
  output logic [7:0]       paddr,   // apb address
  output logic [31:0]      pwdata,  // apb write data
  input  wire logic [31:0] prdata,  // apb read data
  input  wire logic        pready,  // apb ready
  input  wire logic        pslverr  // apb error
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // ==========================================================
  // one access; released paddr and pwdata are scrambled, not left stale
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] r,
                      output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~paddr;
    pwdata <= ~pwdata;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// [test/ugpr_top_tb.sv]
// ugpr_top_tb: random and corner tests of the pattern store
// assumes: ugpr_host drives apb, the bench drives the display fetch
`timescale 1ns/1ns
`default_nettype none
module ugpr_top_tb
  import ugpr_pkg::*;
;
  logic        clk, rstn, dots_ram, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  disp_code, paddr, r;
  logic [3:0]  disp_row;
  logic [4:0]  rom_dots, dots;
  logic [31:0] pwdata, prdata;
  logic [7:0]  mem [32];
  int          err_count, checked, cyc;
  ugpr_top i_ugpr_top (.clk, .rstn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .disp_code, .disp_row,
    .rom_dots, .dots, .dots_ram);
  ugpr_host i_ugpr_host (.clk, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ==========================================================
  // helpers
  task automatic chk(input string n, input logic [8:0] s, input logic [8:0] x);
    checked++;
    if (s !== x) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic close_out;
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_ugpr_host.xfer(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x, input string n,
                    input logic xe = 1'b0);
    i_ugpr_host.xfer(1'b0, a, 8'h00, r, e);
    chk(n, {e, r}, {xe, x});
    chk("upper bits", {8'h00, |prdata[31:8]}, 9'h000);
  endtask
  function automatic logic [5:0] exp_d(input logic [1:0] m,
    input logic [7:0] c, input logic [3:0] w, input logic [4:0] f);
    if (!m[0] || c[7:4] != 4'h0) return {1'b0, f};
    if (!m[1]) return {1'b1, mem[{c[1:0], w[2:0]}][4:0]};
    if (w > ROW12_LAST) return {1'b1, DOTS_DARK};
    return {1'b1, mem[{c[1], w}][4:0]};
  endfunction
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      close_out();
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    int i, m;
    logic [7:0] d;
    rstn = 1'b0;
    disp_code = 8'hF0;
    disp_row = 4'h0;
    rom_dots = 5'h00;
    void'($urandom(32'hA14C7EB4));
    repeat (5) @(posedge clk);
    chk("dots in reset", {3'h0, dots_ram, dots}, 9'h000);
    rstn <= 1'b1;
    @(posedge clk);
    rd(REG_CTRL, 8'h00, "ctrl reset");
    rd(REG_ADDR, 8'h00, "addr reset");
    $display("test reset done");
    wr(REG_CTRL, 8'h00);
    wr(REG_ADDR, 8'h00);
    for (i = 0; i < 32; i++) begin
      d = 8'($urandom);
      if (i[2:0] == 3'h7 || i == 11 || i == 27) d = 8'h00;
      mem[i] = d;
      wr(REG_DATA, d);
    end
    rd(REG_ADDR, 8'h00, "addr wrap");
    for (i = 0; i < 32; i++) rd(REG_DATA, mem[i], "byte");
    rd(REG_STATUS, 8'h01, "read flag");
    wr(REG_STATUS, 8'h00);
    rd(REG_STATUS, 8'h00, "flag clear");
    wr(REG_CTRL, 8'h04);
    wr(REG_ADDR, 8'h05);
    wr(REG_DATA, 8'hE1);
    wr(REG_DATA, 8'h3E);
    mem[5] = 8'hE1;
    mem[4] = 8'h3E;
    rd(REG_ADDR, 8'h03, "addr down");
    rd(8'h10, 8'h00, "unmapped", 1'b1);
    chk("unmapped err", {8'h00, e}, 9'h001);
    $display("test bus done");
    for (m = 0; m < 4; m++) begin
      wr(REG_CTRL, 8'(m));
      repeat (40) begin
        d = 8'($urandom);
        if (d[7]) d[7:4] = 4'h0;
        disp_code <= d;
        disp_row <= m[1] ? 4'($urandom) : {1'b0, 3'($urandom)};
        rom_dots <= 5'($urandom);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("dots", {3'h0, dots_ram, dots}, {3'h0, exp_d(2'(m), disp_code,
          disp_row, rom_dots)});
        @(posedge clk);
      end
      disp_code <= 8'hF0;
      repeat (3) @(posedge clk);
    end
    $display("test display done");
    close_out();
  end
endmodule
`default_nettype wire
